/* File: logic/switch_output_controller.sv */
// Switch output controller: mode selection, limit hysteresis, delays, alarm and inversion.
`timescale 1ns/1ps
`include "switch_output_map.svh"
module switch_output_controller #(
	parameter int unsigned TICK_CYCLES = `SWO_TICK_CYCLES
) (
	input  wire logic                         clk_sys,               // System clock, 20 MHz.
	input  wire logic                         rstn,                  // Async reset, active low.
	input  wire switch_output_pkg::sw_cfg_t   cfg,                   // Configuration settings.
	input  wire switch_output_pkg::pv_set_t   pv_values,             // Process variables, float.
	input  wire logic [11:0]                  pv_valid,              // Per-variable valid flags.
	input  wire switch_output_pkg::diag_t     diag,                  // Alarm and warning events.
	input  wire logic [1:0]                   discrete_input_block,  // Discrete input blocks.
	output logic                              switch_closed,         // Contact, high = conductive.
	output switch_output_pkg::sw_status_t     status                 // Readable switch state.
);
	import switch_output_pkg::*;

	initial begin
		if (TICK_CYCLES < 1) begin
			$error("switch_output_controller: TICK_CYCLES must be at least one");
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Configuration capture. Illegal selector codes fall back to their reset choice.

	sw_cfg_t cfg_q;
	sw_cfg_t cfg_d;

	always_comb begin
		cfg_d = cfg;
		if (cfg.func > FUNC_DIGITAL) begin
			cfg_d.func = sw_func_t'(`SWO_FUNC_RESET);
		end
		if (cfg.diag_cat > DIAG_WARN) begin
			cfg_d.diag_cat = diag_cat_t'(`SWO_DIAG_RESET);
		end
		if (cfg.limit_src > PV_ABS_IFC_AMP) begin
			cfg_d.limit_src = limit_src_t'(`SWO_LIMIT_SRC_RESET);
		end
		if (cfg.di_sel > DI_BLOCK2) begin
			cfg_d.di_sel = di_sel_t'(`SWO_DI_SEL_RESET);
		end
		if (cfg.fail > FAIL_CLOSED) begin
			cfg_d.fail = fail_mode_t'(`SWO_FAIL_RESET);
		end
		if (cfg.on_delay > `SWO_DELAY_MAX_TENTHS) begin
			cfg_d.on_delay = `SWO_DELAY_MAX_TENTHS;
		end
		if (cfg.off_delay > `SWO_DELAY_MAX_TENTHS) begin
			cfg_d.off_delay = `SWO_DELAY_MAX_TENTHS;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_q.func      <= sw_func_t'(`SWO_FUNC_RESET);
			cfg_q.diag_cat  <= diag_cat_t'(`SWO_DIAG_RESET);
			cfg_q.limit_src <= limit_src_t'(`SWO_LIMIT_SRC_RESET);
			cfg_q.di_sel    <= di_sel_t'(`SWO_DI_SEL_RESET);
			cfg_q.fail      <= fail_mode_t'(`SWO_FAIL_RESET);
			cfg_q.invert    <= `SWO_INVERT_RESET;
			cfg_q.on_value  <= `SWO_THRESH_RESET;
			cfg_q.off_value <= `SWO_THRESH_RESET;
			cfg_q.on_delay  <= `SWO_DELAY_RESET;
			cfg_q.off_delay <= `SWO_DELAY_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Delay unit divider: one pulse every tenth of a second.

	logic [31:0] tick_cnt_q;
	logic [31:0] tick_cnt_d;
	logic        tick;

	always_comb begin
		tick       = (tick_cnt_q == 32'(TICK_CYCLES - 1));
		tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Monitored variable selection.

	// Returns the selected value and its validity; off yields an invalid value.
	function automatic logic [32:0] select_pv(input limit_src_t src,
		input pv_set_t values, input logic [11:0] valid);
		logic [3:0] idx;
		idx = 4'(src) - 4'h1;
		if (src == PV_OFF) begin
			select_pv = {1'b0, 32'h0000_0000};
		end else begin
			select_pv = {valid[idx], values[idx]};
		end
	endfunction

	logic [31:0] mon_value;
	logic        mon_valid;
	logic        limit_active;

	always_comb begin
		{mon_valid, mon_value} = select_pv(cfg_q.limit_src, pv_values, pv_valid);
		limit_active           = (cfg_q.func == FUNC_LIMIT) && (cfg_q.limit_src != PV_OFF);
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Threshold comparisons.

	logic above_on;
	logic below_on;
	logic above_off;
	logic below_off;
	logic unord_on;
	logic unord_off;
	logic on_gt_off;
	logic on_lt_off;

	float_compare u_cmp_on (
		.a         (mon_value),
		.b         (cfg_q.on_value),
		.a_gt_b    (above_on),
		.a_lt_b    (below_on),
		.unordered (unord_on)
	);

	float_compare u_cmp_off (
		.a         (mon_value),
		.b         (cfg_q.off_value),
		.a_gt_b    (above_off),
		.a_lt_b    (below_off),
		.unordered (unord_off)
	);

	float_compare u_cmp_thr (
		.a         (cfg_q.on_value),
		.b         (cfg_q.off_value),
		.a_gt_b    (on_gt_off),
		.a_lt_b    (on_lt_off),
		.unordered ()
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Limit hysteresis. Equal thresholds behave as the rising case.

	typedef enum logic [1:0] {
		LIM_OPEN   = 2'b01,
		LIM_CLOSED = 2'b10
	} lim_state_t;

	lim_state_t lim_q;
	lim_state_t lim_d;
	logic       go_closed;
	logic       go_open;
	logic       value_invalid;

	always_comb begin
		value_invalid = !mon_valid || unord_on || unord_off;
		go_closed     = 1'b0;
		go_open       = 1'b0;
		if (on_lt_off) begin
			go_closed = below_on;
			go_open   = above_off;
		end else begin
			go_closed = above_on;
			go_open   = below_off;
		end
		lim_d = lim_q;
		if (cfg_q.limit_src == PV_OFF) begin
			lim_d = LIM_CLOSED;
		end else if (!value_invalid) begin
			unique case (lim_q)
				LIM_OPEN: begin
					if (go_closed) begin
						lim_d = LIM_CLOSED;
					end
				end
				LIM_CLOSED: begin
					if (go_open) begin
						lim_d = LIM_OPEN;
					end
				end
				default: begin
					lim_d = LIM_CLOSED;
				end
			endcase
		end
		// Neither condition met: the state is left as it was.
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lim_q <= LIM_CLOSED;
		end else begin
			lim_q <= lim_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Function selection and delay.

	logic diag_hit;
	logic raw_closed;
	logic delayed_closed;
	logic delay_pending;

	always_comb begin
		unique case (cfg_q.diag_cat)
			DIAG_ALARM:      diag_hit = diag.alarm;
			DIAG_ALARM_WARN: diag_hit = diag.alarm || diag.warning;
			DIAG_WARN:       diag_hit = diag.warning;
			default:         diag_hit = diag.alarm;
		endcase
		unique case (cfg_q.func)
			FUNC_OFF:     raw_closed = 1'b0;
			FUNC_ON:      raw_closed = 1'b1;
			FUNC_DIAG:    raw_closed = !diag_hit;
			FUNC_LIMIT:   raw_closed = (lim_q == LIM_CLOSED);
			FUNC_DIGITAL: begin
				unique case (cfg_q.di_sel)
					DI_BLOCK1: raw_closed = discrete_input_block[0];
					DI_BLOCK2: raw_closed = discrete_input_block[1];
					default:   raw_closed = 1'b0;
				endcase
			end
			default:      raw_closed = 1'b0;
		endcase
	end

	switch_delay_timer #(
		.CNT_W (DELAY_W)
	) u_delay (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.tick        (tick),
		.bypass      (!limit_active),
		.want_closed (raw_closed),
		.on_delay    (cfg_q.on_delay),
		.off_delay   (cfg_q.off_delay),
		.closed_q    (delayed_closed),
		.pending     (delay_pending)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Alarm override, inversion and the contact register.

	logic        forced_closed;
	logic        alarm_forced;
	logic        out_d;
	logic        out_q;
	logic [15:0] trans_q;
	logic [15:0] trans_d;

	always_comb begin
		alarm_forced  = diag.alarm && (cfg_q.fail != FAIL_ACTUAL);
		forced_closed = delayed_closed;
		if (diag.alarm) begin
			unique case (cfg_q.fail)
				FAIL_OPEN:   forced_closed = 1'b0;
				FAIL_CLOSED: forced_closed = 1'b1;
				default:     forced_closed = delayed_closed;
			endcase
		end
		out_d   = forced_closed ^ cfg_q.invert;
		trans_d = (out_d != out_q) ? trans_q + 16'h0001 : trans_q;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_q   <= 1'b0;
			trans_q <= 16'h0000;
		end else begin
			out_q   <= out_d;
			trans_q <= trans_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Status flags, registered alongside the contact.

	sw_status_t status_q;
	sw_status_t status_d;

	always_comb begin
		status_d.closed        = out_d;
		status_d.limit_closed  = (lim_d == LIM_CLOSED);
		status_d.delay_pending = delay_pending;
		status_d.alarm_forced  = alarm_forced;
		status_d.value_invalid = limit_active && value_invalid;
		status_d.transitions   = trans_d;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign switch_closed = out_q;
	assign status        = status_q;

endmodule // switch_output_controller

/* File: logic/switch_output_map.svh */
// Constants, field positions and reset values of the switch output controller.
// Functional notes
// - Off function holds contact open.
// - On function holds contact closed.
// - Diagnostic mode opens only on selected event.
// - Event category: alarm, alarm/warning, warning.
// - Limit mode opens when variable passes limit.
// - On above off: close above, open below.
// - On below off: close below, open above.
// - Switch-on threshold signed float, default zero.
// - Switch-off threshold signed float, default zero.
// - Monitored variable selector, default off.
// - Digital mode follows selected discrete block.
// - Alarm forces actual, open or closed.
// - Inversion swaps open and closed everywhere.
// - Present switch state is readable.
// - Fixed functions allow simulating the output.
`ifndef SWITCH_OUTPUT_MAP_SVH
`define SWITCH_OUTPUT_MAP_SVH

`define SWO_CLK_HZ            20000000
`define SWO_TICK_MS           100
`define SWO_TICK_CYCLES       ((`SWO_CLK_HZ / 1000) * `SWO_TICK_MS)
`define SWO_DELAY_MAX_TENTHS  10'h3e8

`define SWO_FUNC_RESET        3'h0
`define SWO_DIAG_RESET        2'h0
`define SWO_LIMIT_SRC_RESET   4'h0
`define SWO_DI_SEL_RESET      2'h0
`define SWO_FAIL_RESET        2'h1
`define SWO_INVERT_RESET      1'b0
`define SWO_THRESH_RESET      32'h0000_0000
`define SWO_DELAY_RESET       10'h000

`define SWO_FP_SIGN           31
`define SWO_FP_EXP_MSB        30
`define SWO_FP_EXP_LSB        23
`define SWO_FP_MAN_MSB        22

`endif

/* File: logic/switch_output_pkg.sv */
// Types shared by the switch output controller and its helpers.
package switch_output_pkg;

	localparam int unsigned DELAY_W = 10;
	localparam int unsigned PV_NUM  = 12;

	typedef enum logic [2:0] {
		FUNC_OFF     = 3'h0,
		FUNC_ON      = 3'h1,
		FUNC_DIAG    = 3'h2,
		FUNC_LIMIT   = 3'h3,
		FUNC_DIGITAL = 3'h4
	} sw_func_t;

	typedef enum logic [1:0] {
		DIAG_ALARM      = 2'h0,
		DIAG_ALARM_WARN = 2'h1,
		DIAG_WARN       = 2'h2
	} diag_cat_t;

	typedef enum logic [3:0] {
		PV_OFF           = 4'h0,
		PV_LEVEL_LIN     = 4'h1,
		PV_DISTANCE      = 4'h2,
		PV_IFC_LIN       = 4'h3,
		PV_IFC_DISTANCE  = 4'h4,
		PV_UPPER_LAYER   = 4'h5,
		PV_TERM_VOLTAGE  = 4'h6,
		PV_ELEC_TEMP     = 4'h7,
		PV_CAPACITANCE   = 4'h8,
		PV_REL_ECHO_AMP  = 4'h9,
		PV_REL_IFC_AMP   = 4'ha,
		PV_ABS_ECHO_AMP  = 4'hb,
		PV_ABS_IFC_AMP   = 4'hc
	} limit_src_t;

	typedef enum logic [1:0] {
		DI_OFF    = 2'h0,
		DI_BLOCK1 = 2'h1,
		DI_BLOCK2 = 2'h2
	} di_sel_t;

	typedef enum logic [1:0] {
		FAIL_ACTUAL = 2'h0,
		FAIL_OPEN   = 2'h1,
		FAIL_CLOSED = 2'h2
	} fail_mode_t;

	typedef struct packed {
		sw_func_t             func;
		diag_cat_t            diag_cat;
		limit_src_t           limit_src;
		di_sel_t              di_sel;
		fail_mode_t           fail;
		logic                 invert;
		logic [31:0]          on_value;
		logic [31:0]          off_value;
		logic [DELAY_W-1:0]   on_delay;
		logic [DELAY_W-1:0]   off_delay;
	} sw_cfg_t;

	typedef struct packed {
		logic alarm;
		logic warning;
	} diag_t;

	typedef logic [PV_NUM-1:0][31:0] pv_set_t;

	typedef struct packed {
		logic        closed;
		logic        limit_closed;
		logic        delay_pending;
		logic        alarm_forced;
		logic        value_invalid;
		logic [15:0] transitions;
	} sw_status_t;

endpackage

/* File: logic/float_compare.sv */
// Ordered comparison of two single-precision floating-point values.
`timescale 1ns/1ps
`include "switch_output_map.svh"
module float_compare (
	input  wire logic [31:0] a,          // Value under test.
	input  wire logic [31:0] b,          // Reference value.
	output logic             a_gt_b,     // A strictly above b.
	output logic             a_lt_b,     // A strictly below b.
	output logic             unordered   // Either operand is not a number.
);

	// Maps a float onto an unsigned key with the same order; both zeros meet.
	function automatic logic [31:0] order_key(input logic [31:0] f);
		if (f[`SWO_FP_EXP_MSB:0] == 31'h0000_0000) begin
			order_key = 32'h8000_0000;
		end else if (f[`SWO_FP_SIGN]) begin
			order_key = ~f;
		end else begin
			order_key = {1'b1, f[`SWO_FP_EXP_MSB:0]};
		end
	endfunction

	function automatic logic is_nan(input logic [31:0] f);
		is_nan = (&f[`SWO_FP_EXP_MSB:`SWO_FP_EXP_LSB]) && (|f[`SWO_FP_MAN_MSB:0]);
	endfunction

	logic [31:0] key_a;
	logic [31:0] key_b;

	always_comb begin
		key_a     = order_key(a);
		key_b     = order_key(b);
		unordered = is_nan(a) || is_nan(b);
		a_gt_b    = !unordered && (key_a > key_b);
		a_lt_b    = !unordered && (key_a < key_b);
	end

endmodule // float_compare

/* File: logic/switch_delay_timer.sv */
// Holds a requested contact state back by a switch-on or switch-off delay.
`timescale 1ns/1ps
module switch_delay_timer #(
	parameter int unsigned CNT_W = 10
) (
	input  wire logic             clk_sys,       // System clock.
	input  wire logic             rstn,          // Asynchronous reset, active low.
	input  wire logic             tick,          // One-cycle pulse per delay unit.
	input  wire logic             bypass,        // Follow the request at once.
	input  wire logic             want_closed,   // Requested contact state.
	input  wire logic [CNT_W-1:0] on_delay,      // Units to wait before closing.
	input  wire logic [CNT_W-1:0] off_delay,     // Units to wait before opening.
	output logic                  closed_q,      // Delayed contact state.
	output logic                  pending        // A change waits for its delay.
);

	initial begin
		if (CNT_W < 1 || CNT_W > 16) begin
			$error("switch_delay_timer: CNT_W out of range");
		end
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             closed_d;
	logic [CNT_W-1:0] delay;

	always_comb begin
		delay    = want_closed ? on_delay : off_delay;
		cnt_d    = cnt_q;
		closed_d = closed_q;
		pending  = 1'b0;
		if (bypass || want_closed == closed_q) begin
			cnt_d    = '0;
			closed_d = want_closed;
		end else if (cnt_q >= delay) begin
			cnt_d    = '0;
			closed_d = want_closed;
		end else begin
			pending = 1'b1;
			if (tick) begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q    <= '0;
			closed_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			closed_q <= closed_d;
		end
	end

endmodule // switch_delay_timer

/* File: test/ext_circuit.sv */
// External load circuit model switched by the output contact.
`timescale 1ns/1ps
module ext_circuit (
	input  wire logic switch_closed, // Contact, high = conductive.
	output logic      load_on        // Load current flows.
);
	// Current flows only through a conductive contact, never through an open one.
	assign load_on = switch_closed;
endmodule // ext_circuit

/* File: test/switch_output_checker.sv */
// Port-level assertions for the switch output controller.
`timescale 1ns/1ps
module switch_output_checker #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic                          clk_sys,              // Clock.
	input wire logic                          rstn,                 // Reset, active low.
	input wire switch_output_pkg::sw_cfg_t    cfg,                  // Settings.
	input wire switch_output_pkg::pv_set_t    pv_values,            // Variables.
	input wire logic [11:0]                   pv_valid,             // Valid flags.
	input wire switch_output_pkg::diag_t      diag,                 // Events.
	input wire logic [1:0]                    discrete_input_block, // Blocks.
	input wire logic                          switch_closed,        // Contact.
	input wire switch_output_pkg::sw_status_t status                // State.
);
	import switch_output_pkg::*;
	logic [2:0] up_q, up_d;
	sw_cfg_t    c1_q, c1_d, c2_q, c2_d, c3_q, c3_d;
	diag_t      dg_q, dg_d, dg2_q, dg2_d;
	logic [1:0] di_q, di_d, di2_q, di2_d;
	logic       ok, na, inv, ev, dw;
	// Copies line up the inputs with the cycle in which the contact reacts to them.
	// Function, category and block choices pass the delay stage, so they lag three edges;
	// the fail and inversion settings sit after it and lag two, the alarm event itself one.
	always_comb begin
		up_d  = (up_q == 3'h7) ? up_q : up_q + 3'h1;
		c1_d  = cfg;
		c2_d  = c1_q;
		c3_d  = c2_q;
		dg_d  = diag;
		dg2_d = dg_q;
		di_d  = discrete_input_block;
		di2_d = di_q;
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			up_q <= 3'h0;
			c1_q <= '0;
			c2_q <= '0;
			c3_q <= '0;
			dg_q <= '0;
			dg2_q <= '0;
			di_q <= 2'h0;
			di2_q <= 2'h0;
		end else begin
			up_q <= up_d;
			c1_q <= c1_d;
			c2_q <= c2_d;
			c3_q <= c3_d;
			dg_q <= dg_d;
			dg2_q <= dg2_d;
			di_q <= di_d;
			di2_q <= di2_d;
		end
	end
	assign ok = up_q[2];
	assign inv = c2_q.invert;
	assign na = !dg_q.alarm || c2_q.fail == FAIL_ACTUAL;
	assign ev = (c3_q.diag_cat == DIAG_WARN) ? dg2_q.warning :
		(c3_q.diag_cat == DIAG_ALARM_WARN) ? (dg2_q.alarm | dg2_q.warning) : dg2_q.alarm;
	assign dw = (c3_q.di_sel == DI_BLOCK1) ? di2_q[0] :
		(c3_q.di_sel == DI_BLOCK2) ? di2_q[1] : 1'b0;
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_off_open: assert property (ok && na && c3_q.func == FUNC_OFF |-> switch_closed == inv)
		else $error("off function left the contact closed");
	a_on_closed: assert property (ok && na && c3_q.func == FUNC_ON |-> switch_closed == !inv)
		else $error("on function left the contact open");
	a_diag_opens: assert property (ok && na && c3_q.func == FUNC_DIAG |-> switch_closed == (!ev ^ inv))
		else $error("diagnostic mode contact wrong");
	a_digital_follow: assert property (ok && na && c3_q.func == FUNC_DIGITAL |-> switch_closed == (dw ^ inv))
		else $error("digital mode contact wrong");
	a_fail_open: assert property (ok && dg_q.alarm && c2_q.fail == FAIL_OPEN |-> switch_closed == inv)
		else $error("alarm did not force the contact open");
	a_fail_closed: assert property (ok && dg_q.alarm && c2_q.fail == FAIL_CLOSED |-> switch_closed == !inv)
		else $error("alarm did not force the contact closed");
	a_forced_flag: assert property (ok |-> status.alarm_forced == (dg_q.alarm && c2_q.fail != FAIL_ACTUAL))
		else $error("alarm forced flag wrong");
	a_status_closed: assert property (ok |-> status.closed == switch_closed)
		else $error("readable state differs from contact");
	a_count_step: assert property (ok && $changed(switch_closed) |-> status.transitions == $past(status.transitions) + 16'h1)
		else $error("transition count did not step");
	a_hold_between: assert property ((ok && $stable(pv_values) && $stable(cfg) && $stable(pv_valid)) [*4] |=> $stable(status.limit_closed))
		else $error("hysteresis state moved with steady inputs");
endmodule // switch_output_checker
bind switch_output_controller switch_output_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.cfg(cfg),
	.pv_values(pv_values),
	.pv_valid(pv_valid),
	.diag(diag),
	.discrete_input_block(discrete_input_block),
	.switch_closed(switch_closed),
	.status(status)
);

/* File: test/switch_output_controller_tb_top.sv */
// Self-checking bench for the switch output controller.
`timescale 1ns/1ps
module switch_output_controller_tb_top;
	import switch_output_pkg::*;
	localparam logic [31:0] F0 = 32'h0000_0000;
	localparam logic [31:0] FH = 32'h3f00_0000;
	localparam logic [31:0] F1 = 32'h3f80_0000;
	localparam logic [31:0] F3 = 32'h4040_0000;
	localparam logic [31:0] F5 = 32'h40a0_0000;
	localparam logic [31:0] F6 = 32'h40c0_0000;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	sw_cfg_t     cfg;
	pv_set_t     pv_values;
	logic [11:0] pv_valid;
	diag_t       diag;
	logic [1:0]  discrete_input_block;
	logic        switch_closed;
	sw_status_t  status;
	logic        load_on;
	int          n_mismatch = 0;
	int          compares = 0;
	always #25 clk_sys = ~clk_sys;
	switch_output_controller #(.TICK_CYCLES(4)) dut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cfg(cfg),
		.pv_values(pv_values),
		.pv_valid(pv_valid),
		.diag(diag),
		.discrete_input_block(discrete_input_block),
		.switch_closed(switch_closed),
		.status(status)
	);
	ext_circuit load (.switch_closed(switch_closed), .load_on(load_on));
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		compares++;
		if (e !== g) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic sw_is(input logic e);
		chk("contact", e, switch_closed);
		chk("state", e, status.closed);
		chk("load", e, load_on);
	endtask
	// Mode changes need three edges to reach the contact.
	task automatic run(input sw_func_t f, input logic inv, input logic e);
		@(posedge clk_sys);
		cfg.func <= f;
		cfg.invert <= inv;
		cy(3);
		sw_is(e);
	endtask
	// A new value needs three edges to reach the contact.
	task automatic lim(input logic [31:0] v, input logic e);
		@(posedge clk_sys);
		pv_values[0] <= v;
		cy(5);
		sw_is(e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_fixed();
		run(FUNC_ON, 1'b0, 1'b1);
		run(FUNC_ON, 1'b1, 1'b0);
		run(FUNC_OFF, 1'b1, 1'b1);
		run(FUNC_OFF, 1'b0, 1'b0);
	endtask
	task automatic t_diag();
		diag_t d;
		logic  ev;
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 4; k++) begin
				d = diag_t'(k[1:0]);
				ev = (c == 0) ? d.alarm : (c == 1) ? (d.alarm | d.warning) : d.warning;
				@(posedge clk_sys);
				cfg.diag_cat <= diag_cat_t'(c[1:0]);
				cfg.fail <= FAIL_ACTUAL;
				diag <= d;
				run(FUNC_DIAG, 1'b0, !ev);
			end
		end
		@(posedge clk_sys);
		diag <= '0;
	endtask
	task automatic t_alarm();
		for (int m = 0; m < 6; m++) begin
			@(posedge clk_sys);
			diag.alarm <= 1'b1;
			cfg.fail <= fail_mode_t'(m % 3);
			run((m < 3) ? FUNC_ON : FUNC_OFF, 1'b0, m == 0 || m % 3 == 2);
		end
		@(posedge clk_sys);
		cfg.fail <= FAIL_OPEN;
		run(FUNC_ON, 1'b1, 1'b1);
		@(posedge clk_sys);
		diag <= '0;
	endtask
	task automatic t_digital();
		logic e;
		for (int s = 0; s < 3; s++) begin
			for (int b = 0; b < 4; b++) begin
				e = (s == 1) ? b[0] : (s == 2) ? b[1] : 1'b0;
				@(posedge clk_sys);
				cfg.di_sel <= di_sel_t'(s);
				discrete_input_block <= b[1:0];
				run(FUNC_DIGITAL, 1'b0, e);
			end
		end
	endtask
	task automatic t_limit();
		@(posedge clk_sys);
		cfg.func <= FUNC_LIMIT;
		cfg.limit_src <= PV_LEVEL_LIN;
		cfg.on_value <= F5;
		cfg.off_value <= F1;
		lim(F0, 1'b0);
		lim(F6, 1'b1);
		lim(F3, 1'b1);
		lim(FH, 1'b0);
		lim(F3, 1'b0);
		@(posedge clk_sys);
		cfg.on_value <= F1;
		cfg.off_value <= F5;
		lim(F3, 1'b0);
		lim(FH, 1'b1);
		lim(F6, 1'b0);
		@(posedge clk_sys);
		cfg.limit_src <= PV_OFF;
		cy(5);
		sw_is(1'b1);
	endtask
	task automatic t_delay();
		int n;
		@(posedge clk_sys);
		cfg.limit_src <= PV_LEVEL_LIN;
		cfg.on_value <= F5;
		cfg.off_value <= F1;
		lim(FH, 1'b0);
		@(posedge clk_sys);
		cfg.on_delay <= 10'h003;
		lim(F6, 1'b0);
		chk("pending", 1'b1, status.delay_pending);
		n = 5;
		while (switch_closed !== 1'b1 && n < 40) begin
			cy(1);
			n++;
		end
		if (n == 40) begin
			n_mismatch++;
			end_sim();
		end
		chk("on delay", 1'b1, n >= 9 && n <= 17);
		chk("pending", 1'b0, status.delay_pending);
		@(posedge clk_sys);
		cfg.on_delay <= 10'h000;
	endtask
	// An invalid value holds the state; another source is then picked.
	task automatic t_invalid();
		@(posedge clk_sys);
		pv_valid <= 12'hffe;
		lim(FH, 1'b1);
		chk("invalid", 1'b1, status.value_invalid);
		@(posedge clk_sys);
		pv_valid <= 12'hfff;
		cy(5);
		sw_is(1'b0);
		@(posedge clk_sys);
		pv_values[11] <= F6;
		cfg.limit_src <= PV_ABS_IFC_AMP;
		cy(5);
		sw_is(1'b1);
		chk("invalid", 1'b0, status.value_invalid);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		cfg = '0;
		cfg.fail = FAIL_OPEN;
		pv_values = '0;
		pv_valid = 12'hfff;
		diag = '0;
		discrete_input_block = 2'h0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		cy(3);
		sw_is(1'b0);
		t_fixed();
		t_diag();
		t_alarm();
		t_digital();
		t_limit();
		t_delay();
		t_invalid();
		end_sim();
	end
endmodule // switch_output_controller_tb_top
